/* hw/mfio_params.svh */
`ifndef MFIO_PARAMS_SVH
`define MFIO_PARAMS_SVH

// ********************************************************************
// register word indices (byte address is index times four)
// ********************************************************************
`define MFIO_IDX_P4_LATCH 6'h04
`define MFIO_IDX_HC_LATCH 6'h05
`define MFIO_IDX_WAKE_DATA 6'h06
`define MFIO_IDX_ANA_DATA 6'h07
`define MFIO_IDX_P4_DRV 6'h0a
`define MFIO_IDX_P4_PINS 6'h0e
`define MFIO_IDX_HC_PINS 6'h0f
`define MFIO_IDX_WAKE_DIR 6'h10
`define MFIO_IDX_WAKE_IE 6'h11
`define MFIO_IDX_KEY_WAKE_EN 6'h12
`define MFIO_IDX_ANA_DIR 6'h13
`define MFIO_IDX_ANA_IE 6'h14

// ********************************************************************
// widths and field layout
// ********************************************************************
`define MFIO_PORT_W 8
`define MFIO_HC_W 5
`define MFIO_ADDR_W 8
`define MFIO_IDX_LSB 2
`define MFIO_IDX_MSB 7
`define MFIO_DATA_W 32

// ********************************************************************
// reset values
// ********************************************************************
`define MFIO_RST_P4_LATCH 8'hff
`define MFIO_RST_P4_DRV 8'h00
`define MFIO_RST_HC_LATCH 5'h1f
`define MFIO_RST_DIR 8'h00
`define MFIO_RST_IE 8'hff
`define MFIO_RST_DATA 8'h00
`define MFIO_RST_KEY_WAKE_EN 8'h00

`endif

/* hw/mfio_pkg.sv */
`include "mfio_params.svh"

package mfio_pkg;

  // ******************************************************************
  // pin bundles: level to drive and enable of the driver
  // ******************************************************************
  typedef struct packed {
    logic [`MFIO_PORT_W-1:0] dout;
    logic [`MFIO_PORT_W-1:0] oe;
  } mfio_pin8_s;

  typedef struct packed {
    logic [`MFIO_HC_W-1:0] dout;
    logic [`MFIO_HC_W-1:0] oe;
  } mfio_pin5_s;

  // value seen by software when a configurable port is read
  function automatic logic [`MFIO_PORT_W-1:0] mfio_port_read(
    input logic [`MFIO_PORT_W-1:0] latch,
    input logic [`MFIO_PORT_W-1:0] dir,
    input logic [`MFIO_PORT_W-1:0] ie,
    input logic [`MFIO_PORT_W-1:0] pin
  );
    mfio_port_read = (dir & latch) | (~dir & ie & pin);
  endfunction

endpackage

/* hw/mfio_bidir_port.sv */
`include "mfio_params.svh"

// ********************************************************************
// one bit-configurable port: latch, direction and input enable
// ********************************************************************
module mfio_bidir_port
  import mfio_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic wr_data_i, // write strobe for the latch
  input wire logic wr_dir_i, // write strobe for direction
  input wire logic wr_ie_i, // write strobe for input enable
  input wire logic [`MFIO_PORT_W-1:0] wdata_i, // write data
  input wire logic [`MFIO_PORT_W-1:0] pin_i, // pin levels
  output logic [`MFIO_PORT_W-1:0] rdata_o, // data register read view
  output logic [`MFIO_PORT_W-1:0] dir_o, // direction bits
  output mfio_pin8_s pins_o, // registered pin drive
  output logic [`MFIO_PORT_W-1:0] din_o // gated digital inputs
);

  logic [`MFIO_PORT_W-1:0] latch_q;
  logic [`MFIO_PORT_W-1:0] dir_q;
  logic [`MFIO_PORT_W-1:0] ie_q;
  mfio_pin8_s pins_d;
  logic [`MFIO_PORT_W-1:0] din_d;

  // input-mode bits show the pin, so a read-modify-write may copy the
  // pin level into their latch; this is kept as the hardware behaves
  assign rdata_o = mfio_port_read(latch_q, dir_q, ie_q, pin_i);
  assign dir_o = dir_q;

  // a set direction bit drives the latch onto the pin
  assign pins_d.dout = latch_q;
  assign pins_d.oe = dir_q;
  // cleared input enable blocks the digital path for analog use
  assign din_d = ~dir_q & ie_q & pin_i;

  // every pin starts as a digital input with a cleared latch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_q <= `MFIO_RST_DATA;
      dir_q <= `MFIO_RST_DIR;
      ie_q <= `MFIO_RST_IE;
    end else begin
      if (wr_data_i) latch_q <= wdata_i;
      if (wr_dir_i) dir_q <= wdata_i;
      if (wr_ie_i) ie_q <= wdata_i;
    end
  end

  // pin drive and gated inputs leave through flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_o <= '0;
      din_o <= '0;
    end else begin
      pins_o <= pins_d;
      din_o <= din_d;
    end
  end

endmodule // mfio_bidir_port

/* hw/mfio_top.sv */
// Behaviour
// - port4 driver select bit 0 is open-drain sink, 1 is push-pull.
// - reset sets every bit of the high-current port latch to one.
// - high-current port has bits 4..0 only; upper read bits are ignored.
// - high-current port latch and live pin levels read at separate words.
// - reset clears wake port direction and latch, sets input enables.
// - each wake port pin drives its latch when its direction bit is one.
// - wake data reads latch if output, else pin gated by input enable.
// - read-modify-write may copy pin levels into input-mode latches.
// - reset clears analog port direction and latch, sets input enables.
// - analog data reads latch if output, else pin gated by enable.
// - converter channel select alone connects a pin to the converter.
`include "mfio_params.svh"

module mfio_top
  import mfio_pkg::*;
(
  input wire logic CLK_I, // system clock, 200 MHz
  input wire logic RESET_N_I, // async reset, active low
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb access phase
  input wire logic PWRITE_I, // apb direction, high for write
  input wire logic [`MFIO_ADDR_W-1:0] PADDR_I, // apb byte address
  input wire logic [`MFIO_DATA_W-1:0] PWDATA_I, // apb write data
  input wire logic [3:0] PSTRB_I, // apb byte strobes
  output logic [`MFIO_DATA_W-1:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error, unmapped word
  input wire logic [`MFIO_PORT_W-1:0] P4_PIN_I, // port4 pin levels
  output mfio_pin8_s P4_PINS_O, // port4 drive and enable
  input wire logic [`MFIO_HC_W-1:0] HC_PIN_I, // high-current pins
  output mfio_pin5_s HC_PINS_O, // high-current drive/enable
  input wire logic [`MFIO_PORT_W-1:0] WAKE_PIN_I, // wake port pins
  output mfio_pin8_s WAKE_PINS_O, // wake port drive/enable
  output logic [`MFIO_PORT_W-1:0] WAKE_DIN_O, // wake gated inputs
  input wire logic [`MFIO_PORT_W-1:0] ANA_PIN_I, // analog port pins
  output mfio_pin8_s ANA_PINS_O, // analog port drive/enable
  output logic [`MFIO_PORT_W-1:0] ANA_DIN_O, // analog gated inputs
  output logic KEY_WAKE_O, // key wakeup request, high
  input wire logic [2*`MFIO_PORT_W-1:0] CONV_SEL_I, // channel select
  output logic [2*`MFIO_PORT_W-1:0] ANALOG_SW_O // pin to converter
);

  // ******************************************************************
  // register state
  // ******************************************************************
  // software-visible latches and the registered bus answer
  logic [`MFIO_PORT_W-1:0] p4_latch_q;
  logic [`MFIO_PORT_W-1:0] p4_drv_q;
  logic [`MFIO_HC_W-1:0] hc_latch_q;
  logic [`MFIO_PORT_W-1:0] kwe_q;
  logic pready_q;
  logic pslverr_q;
  logic [`MFIO_DATA_W-1:0] prdata_q;

  // ******************************************************************
  // bus decode
  // ******************************************************************
  // address split, transfer phases and the selected read byte
  logic [`MFIO_IDX_MSB-`MFIO_IDX_LSB:0] idx;
  logic aligned;
  logic setup_done;
  logic wr_fire;
  logic lane0;
  logic [`MFIO_PORT_W-1:0] wbyte;
  logic mapped;
  logic [`MFIO_PORT_W-1:0] rd_byte;

  // word index from the byte address; low bits must be zero
  assign idx = PADDR_I[`MFIO_IDX_MSB:`MFIO_IDX_LSB];
  assign aligned = (PADDR_I[`MFIO_IDX_LSB-1:0] == '0);
  // access phase, first cycle: read data is captured then
  assign setup_done = PSEL_I & PENABLE_I & ~pready_q;
  // a write lands only on the edge that completes the transfer
  assign wr_fire = PSEL_I & PENABLE_I & pready_q & PWRITE_I & lane0;
  // only the low lane carries register bits
  assign lane0 = PSTRB_I[0];
  assign wbyte = PWDATA_I[`MFIO_PORT_W-1:0];

  // recognised word addresses, read-only ones included
  function automatic logic is_mapped(
    input logic [`MFIO_IDX_MSB-`MFIO_IDX_LSB:0] i
  );
    unique case (i)
      `MFIO_IDX_P4_LATCH, `MFIO_IDX_HC_LATCH,
      `MFIO_IDX_WAKE_DATA, `MFIO_IDX_ANA_DATA,
      `MFIO_IDX_P4_DRV, `MFIO_IDX_P4_PINS,
      `MFIO_IDX_HC_PINS, `MFIO_IDX_WAKE_DIR,
      `MFIO_IDX_WAKE_IE, `MFIO_IDX_KEY_WAKE_EN,
      `MFIO_IDX_ANA_DIR, `MFIO_IDX_ANA_IE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // misaligned or unknown words answer with an error
  assign mapped = aligned & is_mapped(idx);

  // per-register write strobes
  function automatic logic wr_hit(
    input logic [`MFIO_IDX_MSB-`MFIO_IDX_LSB:0] i,
    input logic [`MFIO_IDX_MSB-`MFIO_IDX_LSB:0] target
  );
    wr_hit = (i == target);
  endfunction

  // one strobe per writable word
  logic wr_p4_latch;
  logic wr_p4_drv;
  logic wr_hc_latch;
  logic wr_kwe;
  logic wr_wake_data;
  logic wr_wake_dir;
  logic wr_wake_ie;
  logic wr_ana_data;
  logic wr_ana_dir;
  logic wr_ana_ie;
  logic wr_ok;

  // pin-level words have no strobe, so writes to them do nothing
  assign wr_ok = wr_fire & aligned;
  assign wr_p4_latch = wr_ok & wr_hit(idx, `MFIO_IDX_P4_LATCH);
  assign wr_p4_drv = wr_ok & wr_hit(idx, `MFIO_IDX_P4_DRV);
  assign wr_hc_latch = wr_ok & wr_hit(idx, `MFIO_IDX_HC_LATCH);
  assign wr_kwe = wr_ok & wr_hit(idx, `MFIO_IDX_KEY_WAKE_EN);
  assign wr_wake_data = wr_ok & wr_hit(idx, `MFIO_IDX_WAKE_DATA);
  assign wr_wake_dir = wr_ok & wr_hit(idx, `MFIO_IDX_WAKE_DIR);
  assign wr_wake_ie = wr_ok & wr_hit(idx, `MFIO_IDX_WAKE_IE);
  assign wr_ana_data = wr_ok & wr_hit(idx, `MFIO_IDX_ANA_DATA);
  assign wr_ana_dir = wr_ok & wr_hit(idx, `MFIO_IDX_ANA_DIR);
  assign wr_ana_ie = wr_ok & wr_hit(idx, `MFIO_IDX_ANA_IE);

  // ******************************************************************
  // configurable ports
  // ******************************************************************
  // read views and directions handed back by the two ports
  logic [`MFIO_PORT_W-1:0] wake_rd;
  logic [`MFIO_PORT_W-1:0] wake_dir;
  logic [`MFIO_PORT_W-1:0] ana_rd;
  logic [`MFIO_PORT_W-1:0] ana_dir;

  // key wakeup and analog pins share this port
  mfio_bidir_port u_wake (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .wr_data_i(wr_wake_data),
    .wr_dir_i(wr_wake_dir),
    .wr_ie_i(wr_wake_ie),
    .wdata_i(wbyte),
    .pin_i(WAKE_PIN_I),
    .rdata_o(wake_rd),
    .dir_o(wake_dir),
    .pins_o(WAKE_PINS_O),
    .din_o(WAKE_DIN_O)
  );

  // interrupt inputs and analog pins share this port
  mfio_bidir_port u_ana (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .wr_data_i(wr_ana_data),
    .wr_dir_i(wr_ana_dir),
    .wr_ie_i(wr_ana_ie),
    .wdata_i(wbyte),
    .pin_i(ANA_PIN_I),
    .rdata_o(ana_rd),
    .dir_o(ana_dir),
    .pins_o(ANA_PINS_O),
    .din_o(ANA_DIN_O)
  );

  // ******************************************************************
  // read selection
  // ******************************************************************
  // upper bits of the high-current port are unimplemented; they read
  // as zero here, but software must not rely on them
  // every source comes in as an argument: a continuous assignment only
  // wakes up on its operands, so hidden reads would leave stale data
  function automatic logic [`MFIO_PORT_W-1:0] rd_sel(
    input logic [`MFIO_IDX_MSB-`MFIO_IDX_LSB:0] i,
    input logic [`MFIO_PORT_W-1:0] p4_latch,
    input logic [`MFIO_PORT_W-1:0] p4_drv,
    input logic [`MFIO_PORT_W-1:0] p4_pin,
    input logic [`MFIO_HC_W-1:0] hc_latch,
    input logic [`MFIO_HC_W-1:0] hc_pin,
    input logic [`MFIO_PORT_W-1:0] wake_view,
    input logic [`MFIO_PORT_W-1:0] wake_dirs,
    input logic [`MFIO_PORT_W-1:0] kwe,
    input logic [`MFIO_PORT_W-1:0] ana_view,
    input logic [`MFIO_PORT_W-1:0] ana_dirs
  );
    unique case (i)
      `MFIO_IDX_P4_LATCH: rd_sel = p4_latch;
      `MFIO_IDX_P4_DRV: rd_sel = p4_drv;
      `MFIO_IDX_P4_PINS: rd_sel = p4_pin;
      `MFIO_IDX_HC_LATCH: rd_sel = {3'h0, hc_latch};
      `MFIO_IDX_HC_PINS: rd_sel = {3'h0, hc_pin};
      `MFIO_IDX_WAKE_DATA: rd_sel = wake_view;
      `MFIO_IDX_WAKE_DIR: rd_sel = wake_dirs;
      // input enables are write-only and read back as zero
      `MFIO_IDX_WAKE_IE: rd_sel = '0;
      `MFIO_IDX_KEY_WAKE_EN: rd_sel = kwe;
      `MFIO_IDX_ANA_DATA: rd_sel = ana_view;
      `MFIO_IDX_ANA_DIR: rd_sel = ana_dirs;
      default: rd_sel = '0;
    endcase
  endfunction

  // unmapped words read as zero alongside the error response
  assign rd_byte = mapped ? rd_sel(idx, p4_latch_q, p4_drv_q, P4_PIN_I,
    hc_latch_q, HC_PIN_I, wake_rd, wake_dir, kwe_q, ana_rd, ana_dir) : '0;

  // ******************************************************************
  // apb answer: one wait state so that data leaves from a flop
  // ******************************************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (setup_done) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q <= {24'h0, rd_byte};
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // bus outputs leave straight from their flops
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign PRDATA_O = prdata_q;

  // ******************************************************************
  // port4, high-current port and key wakeup enable registers
  // ******************************************************************
  // latches idle high so the pins start released
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      p4_latch_q <= `MFIO_RST_P4_LATCH;
      p4_drv_q <= `MFIO_RST_P4_DRV;
      hc_latch_q <= `MFIO_RST_HC_LATCH;
      kwe_q <= `MFIO_RST_KEY_WAKE_EN;
    end else begin
      if (wr_p4_latch) p4_latch_q <= wbyte;
      if (wr_p4_drv) p4_drv_q <= wbyte;
      if (wr_hc_latch) hc_latch_q <= wbyte[`MFIO_HC_W-1:0];
      if (wr_kwe) kwe_q <= wbyte;
    end
  end

  // ******************************************************************
  // pin drivers
  // ******************************************************************
  // next values of the registered pin outputs
  mfio_pin8_s p4_pins_d;
  mfio_pin5_s hc_pins_d;
  logic key_wake_d;

  // open-drain bits only sink; push-pull bits always drive
  assign p4_pins_d.dout = p4_latch_q;
  assign p4_pins_d.oe = p4_drv_q | ~p4_latch_q;
  // the high-current port sinks only, so latch one frees the line
  // for input or two-wire bus use
  assign hc_pins_d.dout = hc_latch_q;
  assign hc_pins_d.oe = ~hc_latch_q;
  // a key press pulls an enabled input-mode pin low
  assign key_wake_d = |(kwe_q & ~wake_dir & ~WAKE_PIN_I);

  // drivers are registered, adding one cycle after a write
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      P4_PINS_O <= '0;
      HC_PINS_O <= '0;
      KEY_WAKE_O <= 1'b0;
    end else begin
      P4_PINS_O <= p4_pins_d;
      HC_PINS_O <= hc_pins_d;
      KEY_WAKE_O <= key_wake_d;
    end
  end

  // ******************************************************************
  // converter connection
  // ******************************************************************
  // switches follow the channel select only; digital setup plays no
  // part, so software must keep analog pins in input mode itself
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ANALOG_SW_O <= '0;
    end else begin
      ANALOG_SW_O <= CONV_SEL_I;
    end
  end

endmodule // mfio_top

/* tb/mfio_properties.sv */
`include "mfio_params.svh"
module mfio_properties
  import mfio_pkg::*;
(
  input wire logic CLK_I, // clock
  input wire logic RESET_N_I, // reset
  input wire logic PSEL_I, // select
  input wire logic PENABLE_I, // access
  input wire logic PWRITE_I, // write
  input wire logic [`MFIO_ADDR_W-1:0] PADDR_I, // address
  input wire logic [`MFIO_DATA_W-1:0] PWDATA_I, // wdata
  input wire logic [3:0] PSTRB_I, // strobes
  input wire logic [`MFIO_DATA_W-1:0] PRDATA_O, // rdata
  input wire logic PREADY_O, // ready
  input wire logic PSLVERR_O, // error
  input wire logic [`MFIO_PORT_W-1:0] P4_PIN_I, // p4 pins
  input wire mfio_pin8_s P4_PINS_O, // p4 drive
  input wire logic [`MFIO_HC_W-1:0] HC_PIN_I, // hc pins
  input wire mfio_pin5_s HC_PINS_O, // hc drive
  input wire logic [`MFIO_PORT_W-1:0] WAKE_PIN_I, // wake pins
  input wire mfio_pin8_s WAKE_PINS_O, // wake drive
  input wire logic [`MFIO_PORT_W-1:0] WAKE_DIN_O, // wake inputs
  input wire logic [`MFIO_PORT_W-1:0] ANA_PIN_I, // ana pins
  input wire mfio_pin8_s ANA_PINS_O, // ana drive
  input wire logic [`MFIO_PORT_W-1:0] ANA_DIN_O, // ana inputs
  input wire logic KEY_WAKE_O, // key wakeup
  input wire logic [2*`MFIO_PORT_W-1:0] CONV_SEL_I, // channel select
  input wire logic [2*`MFIO_PORT_W-1:0] ANALOG_SW_O // converter switch
);
  // ****
  // timing and pin relations
  // ****
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  ready_wait_a: assert property ($rose(PENABLE_I) && PSEL_I |=>
    PREADY_O ##1 !PREADY_O) else $error("ready not after one wait");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 0)
    else $error("error without ready or with data");
  // open drain: a zero latch must always sink
  p4_drain_a: assert property ($past(RESET_N_I) |->
    (~P4_PINS_O.oe & ~P4_PINS_O.dout) == 8'h00) else $error("p4 drive");
  hc_drain_a: assert property ($past(RESET_N_I) |->
    HC_PINS_O.oe == ~HC_PINS_O.dout) else $error("hc drive");
  hc_write_a: assert property (PREADY_O && PWRITE_I && PSTRB_I[0] &&
    PADDR_I == 8'h14 |-> ##2 HC_PINS_O.dout == 5'($past(PWDATA_I, 2)))
    else $error("hc latch not driven");
  hc_upper_a: assert property (PREADY_O && !PWRITE_I &&
    (PADDR_I == 8'h14 || PADDR_I == 8'h3c) |-> PRDATA_O[7:5] == 3'h0)
    else $error("hc upper bits");
  wake_gate_a: assert property ($stable(WAKE_PINS_O.oe) |->
    (WAKE_DIN_O & WAKE_PINS_O.oe) == 8'h00) else $error("wake input");
  ana_gate_a: assert property ($stable(ANA_PINS_O.oe) |->
    (ANA_DIN_O & ANA_PINS_O.oe) == 8'h00) else $error("ana input");
  key_cause_a: assert property (KEY_WAKE_O |->
    $past(WAKE_PIN_I) != 8'hff) else $error("wakeup without low pin");
  conv_sw_a: assert property ($past(RESET_N_I) |->
    ANALOG_SW_O == $past(CONV_SEL_I)) else $error("converter switch");

  cover property (PSLVERR_O);
  cover property (KEY_WAKE_O);
  cover property (PREADY_O && PWRITE_I ##1 PSEL_I);
endmodule // mfio_properties

bind mfio_top mfio_properties i_mfio_properties (.*);

/* tb/mfio_pad.sv */
// ****
// board pad: pulled up, optionally driven from outside
// ****
module mfio_pad #(
  parameter int W = 8
) (
  input wire logic [W-1:0] dout_i, // level from the port
  input wire logic [W-1:0] oe_i, // port driver on
  input wire logic [W-1:0] ext_en_i, // outside driver on
  input wire logic [W-1:0] ext_i, // outside level
  output logic [W-1:0] pin_o // wire level
);
  // contention is not modelled: the port wins when it drives
  assign pin_o = (oe_i & dout_i) | (~oe_i & ~ext_en_i) |
    (~oe_i & ext_en_i & ext_i);
endmodule // mfio_pad

/* tb/test_multi_function_io_ports.sv */
module test_multi_function_io_ports
  import mfio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a, d, e;} mfio_row_s;
  localparam mfio_row_s ROWS[7] = '{'{8'h10, 8'ha5, 8'ha5},
    '{8'h28, 8'h3c, 8'h3c}, '{8'h14, 8'hea, 8'h0a}, '{8'h48, 8'h01, 8'h01},
    '{8'h40, 8'hf0, 8'hf0}, '{8'h4c, 8'h0f, 8'h0f}, '{8'h50, 8'hff, 8'h00}};
  logic CLK_I = 1'b0;
  logic RESET_N_I = 1'b0;
  logic PSEL_I = 1'b0;
  logic PENABLE_I = 1'b0;
  logic PWRITE_I = 1'b0;
  logic [7:0] PADDR_I = 8'h00;
  logic [31:0] PWDATA_I = 32'h0;
  logic [3:0] PSTRB_I = 4'hf;
  logic [15:0] CONV_SEL_I = 16'h0;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_v = 8'h00;
  logic [31:0] PRDATA_O, rd;
  logic PREADY_O, PSLVERR_O, KEY_WAKE_O, se;
  logic [7:0] P4_PIN_I, WAKE_PIN_I, ANA_PIN_I, WAKE_DIN_O, ANA_DIN_O;
  logic [4:0] HC_PIN_I;
  logic [15:0] ANALOG_SW_O;
  mfio_pin8_s P4_PINS_O, WAKE_PINS_O, ANA_PINS_O;
  mfio_pin5_s HC_PINS_O;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;

  mfio_top i_mfio_top (.*);
  mfio_pad #(.W(8)) i_mfio_pad_p4 (.dout_i(P4_PINS_O.dout),
    .oe_i(P4_PINS_O.oe), .ext_en_i(ext_en), .ext_i(ext_v), .pin_o(P4_PIN_I));
  mfio_pad #(.W(5)) i_mfio_pad_hc (.dout_i(HC_PINS_O.dout),
    .oe_i(HC_PINS_O.oe), .ext_en_i(ext_en[4:0]), .ext_i(ext_v[4:0]),
    .pin_o(HC_PIN_I));
  mfio_pad #(.W(8)) i_mfio_pad_wk (.dout_i(WAKE_PINS_O.dout),
    .oe_i(WAKE_PINS_O.oe), .ext_en_i(ext_en), .ext_i(ext_v),
    .pin_o(WAKE_PIN_I));
  mfio_pad #(.W(8)) i_mfio_pad_an (.dout_i(ANA_PINS_O.dout),
    .oe_i(ANA_PINS_O.oe), .ext_en_i(ext_en), .ext_i(ext_v),
    .pin_o(ANA_PIN_I));

  // ****
  // clock, hang guard and helpers
  // ****
  always #2.5 CLK_I = ~CLK_I;

  // the whole run needs well under a thousand cycles
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // entered just after a rising edge; holds the request until ready
  task automatic apb(input logic w, input logic [7:0] a, d);
    PSEL_I <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= {24'h0, d};
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLK_I); while (PREADY_O !== 1'b1);
    rd = PRDATA_O;
    se = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    // one idle edge, so a following call never drives these twice
    @(posedge CLK_I);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
      input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, rd, exp);
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    repeat (12) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk("p4 pins", 32'(P4_PINS_O), 32'hff00);
    chk("hc pins", 32'(HC_PINS_O), 32'h3e0);
    chk("wake pins", 32'(WAKE_PINS_O), 32'h0);
    chk("ana pins", 32'(ANA_PINS_O), 32'h0);
    chk("wake din", 32'(WAKE_DIN_O), 32'hff);
    chk("ana din", 32'(ANA_DIN_O), 32'hff);
    rdchk("hc latch", 8'h14, 32'h1f);
    $display("reset test done");
    foreach (ROWS[i]) begin
      apb(1'b1, ROWS[i].a, ROWS[i].d);
      rdchk("reg", ROWS[i].a, 32'(ROWS[i].e));
    end
    chk("p4 drive", 32'(P4_PINS_O), 32'ha57e);
    chk("hc drive", 32'(HC_PINS_O), 32'h155);
    $display("register table done");
    // outside drives 07: released bits show it, driven bits the port
    ext_en <= 8'hff;
    ext_v <= 8'h07;
    apb(1'b1, 8'h38, 8'h00);
    chk("pin word err", 32'(se), 32'h0);
    rdchk("p4 latch", 8'h10, 32'ha5);
    rdchk("p4 levels", 8'h38, 32'h25);
    rdchk("hc levels", 8'h3c, 32'h02);
    $display("pin words done");
    ext_v <= 8'h33;
    for (int k = 0; k < 2; k++) begin
      logic [7:0] da;
      logic [7:0] dr;
      da = 8'h18 + 8'(4 * k);
      dr = 8'h40 + 8'(12 * k);
      apb(1'b1, dr, 8'hf0);
      apb(1'b1, da, 8'h5a);
      rdchk("data", da, 32'h53);
      apb(1'b1, dr + 8'h04, 8'h0e);
      rdchk("gated", da, 32'h52);
      chk("drive", 32'(k ? ANA_PINS_O : WAKE_PINS_O), 32'h5af0);
      chk("din", 32'(k ? ANA_DIN_O : WAKE_DIN_O), 32'h02);
      // writing back what was read copies pin levels into the latch
      apb(1'b1, da, rd[7:0]);
      apb(1'b1, dr, 8'hff);
      rdchk("rmw", da, 32'h52);
    end
    $display("data port test done");
    ext_v <= 8'hfe;
    apb(1'b1, 8'h40, 8'h00);
    repeat (2) @(posedge CLK_I);
    chk("key wake", 32'(KEY_WAKE_O), 32'h1);
    ext_v <= 8'hff;
    repeat (3) @(posedge CLK_I);
    chk("key idle", 32'(KEY_WAKE_O), 32'h0);
    $display("key wakeup test done");
    apb(1'b1, 8'h11, 8'h00);
    chk("unaligned", 32'(se), 32'h1);
    rdchk("unmapped", 8'h00, 32'h0);
    chk("unmapped err", 32'(se), 32'h1);
    PSTRB_I <= 4'h0;
    apb(1'b1, 8'h10, 8'h00);
    PSTRB_I <= 4'hf;
    rdchk("no strobe", 8'h10, 32'ha5);
    // selected pins go input with the digital path off before sampling
    apb(1'b1, 8'h4c, 8'h00);
    apb(1'b1, 8'h50, 8'h7f);
    @(posedge CLK_I);
    chk("ana din off", 32'(ANA_DIN_O), 32'h7f);
    // no port writes while the converter samples
    CONV_SEL_I <= 16'h8001;
    repeat (3) @(posedge CLK_I);
    chk("conv switch", 32'(ANALOG_SW_O), 32'h8001);
    $display("error and converter test done");
    RESET_N_I <= 1'b0;
    CONV_SEL_I <= 16'h0;
    @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    chk("hc rereset", 32'(HC_PINS_O), 32'h3e0);
    rdchk("dir rereset", 8'h40, 32'h0);
    $display("second reset test done");
    wrap_up();
  end
endmodule // test_multi_function_io_ports
